// >>> bic_err_report.sv
// Error reporting path: system-error message decision and signaled-error flag.
`timescale 1ns/1ns
module bic_err_report (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire bic_pkg::bic_err_t err,
    input  wire logic             serr_enable,
    input  wire logic             clear_sig,
    output logic                  serr_msg,
    output logic                  sig_serr
);

    logic by_cmd;
    logic by_dctl;

    assign by_cmd  = serr_enable & err.primary_side & (err.fatal | err.nonfatal);
    assign by_dctl = (err.fatal & err.dctl_fatal_en) | (err.nonfatal & err.dctl_nonfatal_en);

    // Registered message strobe toward the upstream hub.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serr_msg <= 1'b0;
        end else begin
            serr_msg <= by_cmd | by_dctl;
        end
    end

    // record and clear; a new event wins over the clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sig_serr <= 1'b0;
        end else if (by_cmd) begin
            sig_serr <= 1'b1;
        end else if (clear_sig) begin
            sig_serr <= 1'b0;
        end
    end

endmodule

// >>> bic_hub_model.sv
// Upstream hub model that counts the system-error messages it receives.
`timescale 1ns/1ns
module bic_hub_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic serr_msg,
    output int        serr_count
);
    // Each cycle with the message line high is one message received.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serr_count <= 0;
        end else if (serr_msg) begin
            serr_count <= serr_count + 1;
        end
    end
endmodule

// >>> bic_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the bridge registers.
package bic_pkg;

    // ------------------------------------------------------------------
    // Register offsets and sizes
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFF_DEVICE_ID    = 8'h02;
    localparam logic [7:0]  OFF_COMMAND      = 8'h04;
    localparam logic [7:0]  OFF_STATUS       = 8'h06;
    localparam int          REG_WIDTH        = 16;

    // ------------------------------------------------------------------
    // Identifier fields (values arbitrary, not any real part)
    // ------------------------------------------------------------------
    localparam logic [7:0]  DEVICE_ID_UPPER  = 8'h5a;
    localparam logic [3:0]  DEVICE_ID_MID    = 4'h3;
    localparam logic [3:0]  DEVICE_ID_LOW    = 4'hc;

    // ------------------------------------------------------------------
    // Command and status bit positions
    // ------------------------------------------------------------------
    localparam int          CMD_IRQ_DISABLE  = 10;
    localparam int          CMD_FAST_B2B     = 9;
    localparam int          CMD_SERR_ENABLE  = 8;
    localparam int          CMD_PARITY_RESP  = 6;
    localparam int          STS_SIG_SERR     = 14;
    localparam int          STS_MASTER_PERR  = 8;
    localparam logic [15:0] COMMAND_RESET    = 16'h0000;
    localparam logic [15:0] COMMAND_WR_MASK  = 16'h0547;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  offset;
        logic [1:0]  byte_en;
        logic [15:0] wdata;
    } bic_cfg_req_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
        logic dctl_fatal_en;
        logic dctl_nonfatal_en;
        logic primary_side;
    } bic_err_t;

endpackage

// >>> bic_regs.sv
// Identifier and command registers of the virtual bridge, with interrupt and error gating.
//
// Behaviour
// - Read-only 16-bit device identifier built from fields 15:8, 7:4, 3:0.
// - Legacy interrupt assert messages allowed only while command bit 10 is clear.
// - Setting bit 10 deasserts any currently asserted emulated interrupt.
// - Bit 10 gates only own interrupts; forwarded MSIs and INTx pass untouched.
// - Fast back-to-back bit 9 always reads zero, writes ignored.
// - Bit 8 set: send system-error message for primary-side fatal/non-fatal errors.
// - Report if command bit or device-control enables allow it.
// - Command-enabled system-error messages are recorded in the status register.
// - Bit 6 clear: master data parity error status can never set.
// - Signaled system-error status bit sets on such messages, write-one clears.
`timescale 1ns/1ns
module bic_regs (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire bic_pkg::bic_cfg_req_t cfg,
    output logic [15:0]               cfg_rdata,
    output logic                      cfg_rvalid,
    input  wire logic                 own_irq_req,
    output logic                      own_irq_assert,
    output logic                      own_irq_msg,
    input  wire logic                 fwd_irq_in,
    output logic                      fwd_irq_out,
    input  wire bic_pkg::bic_err_t    err,
    input  wire logic                 master_perr_event,
    output logic                      serr_msg,
    output logic [15:0]               command_out
);

    // ------------------------------------------------------------------
    // Byte-lane write helper
    // ------------------------------------------------------------------
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0]  be,
                                               input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
        return (old_v & ~lanes) | (new_v & lanes);
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] command;
    logic        master_perr;
    logic        sig_serr;
    logic        wr_cmd;
    logic        wr_sts;
    logic [15:0] ident;
    logic [15:0] status;
    logic        irq_was_on;

    assign wr_cmd = cfg.write && cfg.offset == bic_pkg::OFF_COMMAND;
    assign wr_sts = cfg.write && cfg.offset == bic_pkg::OFF_STATUS;

    assign ident = {bic_pkg::DEVICE_ID_UPPER, bic_pkg::DEVICE_ID_MID, bic_pkg::DEVICE_ID_LOW};

    // Command register; only bits 10, 8, 6 and 2:0 hold state.
    // write mask
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            command <= bic_pkg::COMMAND_RESET;
        end else if (wr_cmd) begin
            command <= lane_merge(command, cfg.wdata, cfg.byte_en, bic_pkg::COMMAND_WR_MASK);
        end
    end
    assign command_out = command;

    // Master data parity error flag; set wins over write-one clear.
    // parity gating
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            master_perr <= 1'b0;
        end else if (master_perr_event && command[bic_pkg::CMD_PARITY_RESP]) begin
            master_perr <= 1'b1;
        end else if (wr_sts && cfg.byte_en[1] && cfg.wdata[bic_pkg::STS_MASTER_PERR]) begin
            master_perr <= 1'b0;
        end
    end

    // Error reporting path.
    bic_err_report u_err (
        .clk         (clk),
        .reset       (reset),
        .err         (err),
        .serr_enable (command[bic_pkg::CMD_SERR_ENABLE]),
        .clear_sig   (wr_sts && cfg.byte_en[1] && cfg.wdata[bic_pkg::STS_SIG_SERR]),
        .serr_msg    (serr_msg),
        .sig_serr    (sig_serr)
    );

    assign status = {1'b0, sig_serr, 5'h00, master_perr, 8'h00};

    // ------------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------------
    // level drops one cycle after the disable bit is set.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            own_irq_assert <= 1'b0;
        end else begin
            own_irq_assert <= own_irq_req & ~command[bic_pkg::CMD_IRQ_DISABLE];
        end
    end

    // Remember previous level to emit assert and deassert messages on changes.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_was_on <= 1'b0;
        end else begin
            irq_was_on <= own_irq_assert;
        end
    end
    assign own_irq_msg = own_irq_assert ^ irq_was_on;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fwd_irq_out <= 1'b0;
        end else begin
            fwd_irq_out <= fwd_irq_in;
        end
    end

    // ------------------------------------------------------------------
    // Read path, one cycle latency, unmapped offsets read zero
    // ------------------------------------------------------------------
    // fixed values returned
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_rdata  <= 16'h0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg.read;
            if (cfg.read) begin
                case (cfg.offset)
                    bic_pkg::OFF_DEVICE_ID: cfg_rdata <= ident;
                    bic_pkg::OFF_COMMAND:   cfg_rdata <= command;
                    bic_pkg::OFF_STATUS:    cfg_rdata <= status;
                    default:                cfg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// >>> bic_regs_chk.sv
// Checker of the register block behaviour at its ports.
`timescale 1ns/1ns
module bic_regs_chk (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire bic_pkg::bic_cfg_req_t cfg,
    input wire logic [15:0]           cfg_rdata,
    input wire logic                  cfg_rvalid,
    input wire logic                  own_irq_req,
    input wire logic                  own_irq_assert,
    input wire logic                  own_irq_msg,
    input wire logic                  fwd_irq_in,
    input wire logic                  fwd_irq_out,
    input wire bic_pkg::bic_err_t     err,
    input wire logic                  serr_msg,
    input wire logic [15:0]           command_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Primary-side error allowed by the command enable.
    sequence s_cmd_err;
        command_out[8] && err.primary_side && (err.fatal || err.nonfatal);
    endsequence
    // Error allowed by the device-control enables.
    sequence s_dctl_err;
        (err.fatal && err.dctl_fatal_en) || (err.nonfatal && err.dctl_nonfatal_en);
    endsequence
    AST_ID: assert property (
        cfg.read && cfg.offset == 8'h02 |=> cfg_rdata == 16'h5a3c) else $error("bad id");
    AST_FAST_BACK_TO_BACK_ENABLE: assert property (
        !command_out[9]) else $error("fast bit set");
    AST_RSV: assert property (
        command_out[15:11] == 5'h00 && !command_out[7]) else $error("reserved set");
    AST_IRQ_OFF: assert property (
        command_out[10] |=> !own_irq_assert) else $error("irq not gated");
    AST_IRQ_ON: assert property (
        own_irq_req && !command_out[10] |=> own_irq_assert) else $error("irq lost");
    AST_FWD: assert property (
        1'b1 |=> fwd_irq_out == $past(fwd_irq_in)) else $error("forward blocked");
    AST_SERR_CMD: assert property (
        s_cmd_err |=> serr_msg) else $error("no serr message");
    AST_SERR_DCTL: assert property (
        s_dctl_err |=> serr_msg) else $error("no dctl serr message");
    // Read data is flagged valid exactly one cycle after each read request.
    AST_RVALID: assert property (
        1'b1 |=> cfg_rvalid == $past(cfg.read)) else $error("read valid wrong");
    // Every change of the emulated interrupt level sends a message.
    AST_IRQ_MSG: assert property (
        own_irq_assert != $past(own_irq_assert) |-> own_irq_msg) else $error("irq message lost");
endmodule
bind bic_regs bic_regs_chk i_chk (.clk(clk), .reset(reset), .cfg(cfg), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .own_irq_req(own_irq_req), .own_irq_assert(own_irq_assert),
    .own_irq_msg(own_irq_msg), .fwd_irq_in(fwd_irq_in),
    .fwd_irq_out(fwd_irq_out), .err(err), .serr_msg(serr_msg), .command_out(command_out));

// >>> bridge_ident_command_regs_test.sv
// Self-checking testbench of the bridge identifier and command registers.
`timescale 1ns/1ns
module bridge_ident_command_regs_test;
    logic clk = 1'b0, reset = 1'b1, own_irq_req = 1'b0, fwd_irq_in = 1'b0;
    logic master_perr_event = 1'b0, serr_msg, own_irq_assert, fwd_irq_out, rv, irq_msg;
    logic [15:0] cfg_rdata, command_out, cmd, m, lf = 16'h003b;
    logic [7:0] cases [6] = '{8'hc7, 8'ha7, 8'hc0, 8'h44, 8'h56, 8'h2a};
    bic_pkg::bic_cfg_req_t cfg = '0;
    bic_pkg::bic_err_t err = '0;
    int err_total = 0, n_checks = 0, serr_count, c0;
    // Clock of 10 ns period.
    always #5 clk = ~clk;
    bic_regs i_dut (.clk(clk), .reset(reset), .cfg(cfg), .cfg_rdata(cfg_rdata), .cfg_rvalid(rv),
        .own_irq_req(own_irq_req), .own_irq_assert(own_irq_assert), .own_irq_msg(irq_msg),
        .fwd_irq_in(fwd_irq_in), .fwd_irq_out(fwd_irq_out), .err(err), .serr_msg(serr_msg),
        .master_perr_event(master_perr_event), .command_out(command_out));
    bic_hub_model i_hub (.clk(clk), .reset(reset), .serr_msg(serr_msg), .serr_count(serr_count));
    // Next value of the pseudo-random sequence.
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, got);
        chk(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic wr(input logic [7:0] off, input logic [1:0] be, input logic [15:0] d);
        @(posedge clk) #1;
        cfg = '{1'b1, 1'b0, off, be, d};
        @(posedge clk) #1;
        cfg.write = 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] off, input logic [15:0] exp);
        @(posedge clk) #1;
        cfg = '{1'b0, 1'b1, off, 2'h3, 16'h0000};
        @(posedge clk) #1;
        cfg.read = 1'b0;
        chk1("read valid", 1'b1, rv);
        chk(what, exp, cfg_rdata);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    // Main sequence of scenarios.
    initial begin
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        rdc("command", 8'h04, 16'h0000);
        rdc("ident", 8'h02, 16'h5a3c);
        wr(8'h02, 2'h3, 16'hffff);
        rdc("ident", 8'h02, 16'h5a3c);
        rdc("unmapped", 8'h10, 16'h0000);
        cmd = 16'h0000;
        for (int i = 0; i < 10; i++) begin
            lf = step(lf);
            if (i == 0) lf = 16'hffff;
            m = {{8{lf[5]}}, {8{lf[4]}}} & 16'h0547;
            cmd = (cmd & ~m) | (lf & m);
            wr(8'h04, lf[5:4], lf);
            rdc("command", 8'h04, cmd);
            chk("command out", cmd, command_out);
        end
        wr(8'h04, 2'h3, 16'h0000);
        own_irq_req = 1'b1;
        fwd_irq_in = 1'b1;
        @(posedge clk) #1;
        chk1("irq on", 1'b1, own_irq_assert);
        chk1("irq assert message", 1'b1, irq_msg);
        wr(8'h04, 2'h3, 16'h0400);
        @(posedge clk) #1;
        chk1("irq off", 1'b0, own_irq_assert);
        chk1("irq deassert message", 1'b1, irq_msg);
        chk1("forward", 1'b1, fwd_irq_out);
        @(posedge clk) #1;
        chk1("irq quiet", 1'b0, irq_msg);
        own_irq_req = 1'b0;
        for (int i = 0; i < 6; i++) begin
            wr(8'h04, 2'h3, {7'h00, cases[i][7], 8'h00});
            c0 = serr_count;
            err = bic_pkg::bic_err_t'(cases[i][6:2]);
            @(posedge clk) #1;
            err = '0;
            chk1("serr", cases[i][1], serr_msg);
            rdc("status", 8'h06, {1'b0, cases[i][0], 14'h0000});
            chk("messages", 16'(c0 + cases[i][1]), 16'(serr_count));
            wr(8'h06, 2'h2, 16'h4000);
            rdc("status clear", 8'h06, 16'h0000);
        end
        for (int p = 0; p < 2; p++) begin
            wr(8'h04, 2'h3, {9'h000, p[0], 6'h00});
            master_perr_event = 1'b1;
            @(posedge clk) #1;
            master_perr_event = 1'b0;
            rdc("parity status", 8'h06, {7'h00, p[0], 8'h00});
        end
        // Reset in mid-run returns command and status to zero.
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        chk("command after reset", 16'h0000, command_out);
        rdc("status after reset", 8'h06, 16'h0000);
        print_verdict();
    end
endmodule
